/* File: rtl/bsrc_pkg.sv */
// Purpose: shared constants and types for boot select and reset control
// Assumes: one clock, synchronous active-high reset
// Notes: boot codes follow the strap tables of both package variants
package bsrc_pkg;
  localparam int WDOG_W = 32;
  // three-bit strap codes
  localparam logic [2:0] BOOT3_SPI_SLAVE = 3'h0;
  localparam logic [2:0] BOOT3_SPI_MASTER = 3'h1;
  localparam logic [2:0] BOOT3_ASYNC_FLASH = 3'h2;
  localparam logic [2:0] BOOT3_NO_BOOT = 3'h3;
  // two-bit strap codes
  localparam logic [1:0] BOOT2_SPI_SLAVE = 2'h0;
  localparam logic [1:0] BOOT2_SPI_MASTER = 2'h1;
  localparam logic [1:0] BOOT2_RESERVED = 2'h2;
  localparam logic [1:0] BOOT2_NO_BOOT = 2'h3;
  // width of reset pulse issued to core and peripherals
  localparam int RST_PULSE_CYC = 16;
  localparam logic [WDOG_W-1:0] WDOG_RESET_VAL = 32'hffffffff;

  typedef enum logic [2:0] {
    BSRC_BOOT_SPI_SLAVE,
    BSRC_BOOT_SPI_MASTER,
    BSRC_BOOT_ASYNC_FLASH,
    BSRC_BOOT_NONE,
    BSRC_BOOT_RESERVED
  } bsrc_boot_t;

  typedef struct packed {
    logic core_rst;
    logic periph_rst;
    logic pll_rst;
    logic sdram_rst;
    logic boot_start;
  } bsrc_rst_t;
endpackage

/* File: rtl/bsrc_wdog.sv */
// Purpose: 32-bit down-counting software watchdog
// Assumes: load value is written before enable is raised
// Notes: expire is a one-cycle pulse when the count reaches zero
`timescale 1ns/100ps
`default_nettype none
module bsrc_wdog #(
  parameter int W = bsrc_pkg::WDOG_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // software control
  input wire logic load_wr_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic reload_i,
  input wire logic enable_i,
  // status
  output logic [W-1:0] count_o,
  output logic expire_o
);
  logic [W-1:0] load_r, load_nxt;
  logic [W-1:0] cnt_r, cnt_nxt;
  logic exp_r, exp_nxt;

  always_comb begin
    load_nxt = load_r;
    cnt_nxt = cnt_r;
    exp_nxt = 1'b0;
    if (load_wr_i) begin
      load_nxt = load_val_i;
    end
    if (!enable_i) begin
      // idle counter tracks the programmed value so enabling starts from it
      cnt_nxt = load_wr_i ? load_val_i : load_r; // [R9]
    end else if (reload_i) begin
      cnt_nxt = load_r; // [R12]
    end else if (cnt_r == '0) begin
      exp_nxt = 1'b1; // [R8]
      cnt_nxt = load_r;
    end else begin
      cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1}; // [R7] [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_r <= bsrc_pkg::WDOG_RESET_VAL;
      cnt_r <= bsrc_pkg::WDOG_RESET_VAL;
      exp_r <= 1'b0;
    end else begin
      load_r <= load_nxt;
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign count_o = cnt_r;
  assign expire_o = exp_r;
endmodule
`default_nettype wire

/* File: rtl/bsrc_top.sv */
// Purpose: boot source decode, warm reset and watchdog reset control
// Assumes: rst_i is the power-on reset; strap pins are asynchronous
// Notes: wide_straps_i selects three-bit or two-bit strap decoding
//
// Overview of operation
// R1: at power-up, load internal memory from flash, SPI master or SPI slave.
// R2: three-bit straps 000 slave, 001 master, 010 parallel flash boot.
// R3: three-bit 011 runs from ROM; codes 1xx are reserved, board avoids.
// R4: two-bit 00 slave, 01 master, 11 ROM; 10 reserved, board avoids.
// R5: running reset clears core and peripherals, spares PLL, SDRAM, no boot.
// R6: external request on reset-out pin starts a running reset.
// R7: provide a 32-bit down-counting watchdog reloaded by software.
// R8: watchdog expiry before reload generates a system reset.
// R9: software writes watchdog count before enabling the watchdog.
// R10: watchdog reset clears both core and all internal peripherals.
// R11: straps sampled at power-on reset release, held until next one.
// R12: watchdog decrements each cycle; reload restores programmed count.
`timescale 1ns/100ps
`default_nettype none
module bsrc_top #(
  parameter int WDOG_W = bsrc_pkg::WDOG_W,
  parameter int PULSE_CYC = bsrc_pkg::RST_PULSE_CYC
) (
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_i,
  // strap pins
  input wire logic wide_straps_i,
  input wire logic [2:0] boot_select_pins_i,
  // shared reset-out / warm reset pin, low active
  input wire logic reset_out_warm_reset_in_n_i,
  output logic reset_out_warm_reset_in_n_o,
  output logic reset_out_warm_reset_in_oe_o,
  // watchdog software port
  input wire logic wdog_load_wr_i,
  input wire logic [WDOG_W-1:0] wdog_load_val_i,
  input wire logic wdog_reload_i,
  input wire logic wdog_enable_i,
  output logic [WDOG_W-1:0] wdog_count_o,
  // boot mode and resets
  output bsrc_pkg::bsrc_boot_t boot_mode_o,
  output logic boot_reserved_o,
  output bsrc_pkg::bsrc_rst_t rst_o
);
  typedef enum logic [1:0] {
    BSRC_ST_POR,
    BSRC_ST_RUN,
    BSRC_ST_WARM,
    BSRC_ST_WDOG
  } bsrc_state_t;

  function automatic bsrc_pkg::bsrc_boot_t bsrc_decode(input logic wide,
                                                       input logic [2:0] pins);
    bsrc_pkg::bsrc_boot_t m;
    m = bsrc_pkg::BSRC_BOOT_RESERVED;
    if (wide) begin
      if (pins[2]) begin
        m = bsrc_pkg::BSRC_BOOT_RESERVED; // [R3]
      end else begin
        case (pins)
          bsrc_pkg::BOOT3_SPI_SLAVE: m = bsrc_pkg::BSRC_BOOT_SPI_SLAVE; // [R2]
          bsrc_pkg::BOOT3_SPI_MASTER: m = bsrc_pkg::BSRC_BOOT_SPI_MASTER; // [R2]
          bsrc_pkg::BOOT3_ASYNC_FLASH: m = bsrc_pkg::BSRC_BOOT_ASYNC_FLASH; // [R2]
          bsrc_pkg::BOOT3_NO_BOOT: m = bsrc_pkg::BSRC_BOOT_NONE; // [R3]
          default: m = bsrc_pkg::BSRC_BOOT_RESERVED;
        endcase
      end
    end else begin
      case (pins[1:0])
        bsrc_pkg::BOOT2_SPI_SLAVE: m = bsrc_pkg::BSRC_BOOT_SPI_SLAVE; // [R4]
        bsrc_pkg::BOOT2_SPI_MASTER: m = bsrc_pkg::BSRC_BOOT_SPI_MASTER; // [R4]
        bsrc_pkg::BOOT2_NO_BOOT: m = bsrc_pkg::BSRC_BOOT_NONE; // [R4]
        bsrc_pkg::BOOT2_RESERVED: m = bsrc_pkg::BSRC_BOOT_RESERVED; // [R4]
        default: m = bsrc_pkg::BSRC_BOOT_RESERVED;
      endcase
    end
    return m;
  endfunction

  // only the three loader modes start a boot; rom and reserved straps stay quiet
  function automatic logic bsrc_boots(input bsrc_pkg::bsrc_boot_t m);
    logic b;
    b = 1'b0;
    case (m)
      bsrc_pkg::BSRC_BOOT_SPI_SLAVE: b = 1'b1; // [R1] [R2] [R4]
      bsrc_pkg::BSRC_BOOT_SPI_MASTER: b = 1'b1; // [R1] [R2] [R4]
      bsrc_pkg::BSRC_BOOT_ASYNC_FLASH: b = 1'b1; // [R1] [R2]
      bsrc_pkg::BSRC_BOOT_NONE: b = 1'b0; // [R3] [R4]
      default: b = 1'b0;
    endcase
    return b;
  endfunction

  localparam int CW = $clog2(PULSE_CYC + 1);

  // synchronisers for asynchronous pins
  logic [3:0] pin_s1_r, pin_s2_r;
  logic [3:0] pin_s1_nxt, pin_s2_nxt;
  logic ext_s1_r, ext_s2_r, ext_s3_r;
  logic ext_s1_nxt, ext_s2_nxt, ext_s3_nxt;

  // control state
  bsrc_state_t st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic latched_r, latched_nxt;
  bsrc_pkg::bsrc_boot_t mode_r, mode_nxt;
  bsrc_pkg::bsrc_rst_t rst_r, rst_nxt;
  logic drive_r, drive_nxt;
  logic wdog_expire;
  logic ext_req;

  bsrc_wdog #(
    .W(WDOG_W)
  ) bsrc_wdog_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_wr_i(wdog_load_wr_i),
    .load_val_i(wdog_load_val_i),
    .reload_i(wdog_reload_i),
    .enable_i(wdog_enable_i),
    .count_o(wdog_count_o),
    .expire_o(wdog_expire)
  );

  always_comb begin
    pin_s1_nxt = {wide_straps_i, boot_select_pins_i};
    pin_s2_nxt = pin_s1_r;
    ext_s1_nxt = ~reset_out_warm_reset_in_n_i;
    ext_s2_nxt = ext_s1_r;
    ext_s3_nxt = ext_s2_r;
  end

  // our own drive of the pin is masked so it cannot retrigger itself
  assign ext_req = ext_s2_r & ~ext_s3_r & ~drive_r; // [R6]

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    latched_nxt = latched_r;
    mode_nxt = mode_r;
    rst_nxt = rst_r;
    drive_nxt = drive_r;
    rst_nxt.boot_start = 1'b0;
    case (st_r)
      BSRC_ST_POR: begin
        // straps settle through the synchroniser before capture
        if (cnt_r == CW'(PULSE_CYC)) begin
          if (!latched_r) begin
            mode_nxt = bsrc_decode(pin_s2_r[3], pin_s2_r[2:0]); // [R11]
            latched_nxt = 1'b1; // [R11]
          end
          rst_nxt = '0;
          rst_nxt.boot_start = bsrc_boots(mode_nxt); // [R1] [R3]
          drive_nxt = 1'b0;
          st_nxt = BSRC_ST_RUN;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      BSRC_ST_RUN: begin
        cnt_nxt = '0;
        if (wdog_expire) begin
          rst_nxt.core_rst = 1'b1; // [R8] [R10]
          rst_nxt.periph_rst = 1'b1; // [R10]
          drive_nxt = 1'b1;
          st_nxt = BSRC_ST_WDOG;
        end else if (ext_req) begin
          rst_nxt.core_rst = 1'b1; // [R5]
          rst_nxt.periph_rst = 1'b1; // [R5]
          st_nxt = BSRC_ST_WARM;
        end
      end
      BSRC_ST_WARM, BSRC_ST_WDOG: begin
        // pll and sdram stay out of reset; no boot is started here
        if (cnt_r == CW'(PULSE_CYC - 1)) begin
          rst_nxt.core_rst = 1'b0; // [R5]
          rst_nxt.periph_rst = 1'b0;
          drive_nxt = 1'b0;
          st_nxt = BSRC_ST_RUN;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      default: begin
        st_nxt = BSRC_ST_POR;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      st_r <= BSRC_ST_POR;
      cnt_r <= '0;
      latched_r <= 1'b0;
      mode_r <= bsrc_pkg::BSRC_BOOT_RESERVED;
      rst_r <= '{core_rst: 1'b1, periph_rst: 1'b1, pll_rst: 1'b1,
                 sdram_rst: 1'b1, boot_start: 1'b0};
      drive_r <= 1'b1;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
      ext_s1_r <= ext_s1_nxt;
      ext_s2_r <= ext_s2_nxt;
      ext_s3_r <= ext_s3_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      latched_r <= latched_nxt;
      mode_r <= mode_nxt;
      rst_r <= rst_nxt;
      drive_r <= drive_nxt;
    end
  end

  // pin is open-drain: only ever pulled low
  assign reset_out_warm_reset_in_n_o = 1'b0;
  assign reset_out_warm_reset_in_oe_o = drive_r;
  assign boot_mode_o = mode_r;
  assign boot_reserved_o = (mode_r == bsrc_pkg::BSRC_BOOT_RESERVED);
  assign rst_o = rst_r;
endmodule
`default_nettype wire

/* File: sim/bsrc_board.sv */
// Purpose: board straps and external reset source
// Assumes: reset pin is open drain with a pull-up
// Notes: straps pass through as held by the bench
`timescale 1ns/100ps
`default_nettype none
module bsrc_board (
  // bench control
  input wire logic oe_i,
  input wire logic req_i,
  input wire logic wide_i,
  input wire logic [2:0] code_i,
  // pins
  output logic wide_o,
  output logic [2:0] pins_o,
  output logic pin_n_o
);
  assign wide_o = wide_i;
  assign pins_o = code_i;
  // pull-up wins only when nobody pulls low
  assign pin_n_o = ~(oe_i | req_i);
endmodule
`default_nettype wire

/* File: sim/bsrc_checker.sv */
// Purpose: port checks for boot select and reset control
// Assumes: straps steady during power-on reset
// Notes: bound to the top module
`timescale 1ns/100ps
`default_nettype none
module bsrc_checker #(
  parameter int WDOG_W = 32,
  parameter int PULSE_CYC = 16
) (
  // clock, reset, straps
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wide_straps_i,
  input wire logic [2:0] boot_select_pins_i,
  // reset pin
  input wire logic reset_out_warm_reset_in_n_i,
  input wire logic reset_out_warm_reset_in_oe_o,
  // watchdog
  input wire logic wdog_load_wr_i,
  input wire logic wdog_reload_i,
  input wire logic wdog_enable_i,
  input wire logic [WDOG_W-1:0] wdog_count_o,
  // results
  input wire bsrc_pkg::bsrc_boot_t boot_mode_o,
  input wire logic boot_reserved_o,
  input wire bsrc_pkg::bsrc_rst_t rst_o
);
  logic [7:0] cnt_r;
  // straps that load nothing: rom execution or a reserved code
  logic strap_quiet;
  assign strap_quiet = wide_straps_i ? (boot_select_pins_i[2] || boot_select_pins_i == 3'h3)
    : boot_select_pins_i[1];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // length of the current core reset, in cycles
  always_ff @(posedge clk_i) begin
    cnt_r <= rst_o.core_rst ? cnt_r + 8'h01 : 8'h00;
  end
  a_warm_spare: assert property ($rose(rst_o.core_rst) |-> rst_o.periph_rst
    && !rst_o.pll_rst && !rst_o.sdram_rst && !rst_o.boot_start) else $error("pll or boot hit");
  a_warm_start: assert property ($fell(reset_out_warm_reset_in_n_i)
    && !reset_out_warm_reset_in_oe_o && !rst_o.pll_rst && !rst_o.core_rst
    |-> ##[2:4] rst_o.core_rst) else $error("pin request lost");
  a_pulse_len: assert property ($fell(rst_o.core_rst) && !$past(rst_o.pll_rst)
    |-> cnt_r == PULSE_CYC) else $error("reset pulse length");
  a_mode_hold: assert property (!rst_o.pll_rst && !$past(rst_o.pll_rst)
    |-> $stable(boot_mode_o)) else $error("boot mode moved");
  a_decode_wide: assert property ($fell(rst_o.pll_rst) && wide_straps_i
    |-> boot_mode_o == (boot_select_pins_i[2] ? bsrc_pkg::BSRC_BOOT_RESERVED
    : bsrc_pkg::bsrc_boot_t'(boot_select_pins_i))
    && boot_reserved_o == boot_select_pins_i[2]) else $error("wide decode");
  a_decode_narrow: assert property ($fell(rst_o.pll_rst) && !wide_straps_i
    |-> boot_mode_o == (boot_select_pins_i[1:0] == 2'h2 ? bsrc_pkg::BSRC_BOOT_RESERVED
    : bsrc_pkg::bsrc_boot_t'({1'b0, boot_select_pins_i[1:0]}))
    && boot_reserved_o == (boot_select_pins_i[1:0] == 2'h2)) else $error("narrow decode");
  a_rom_noboot: assert property ($fell(rst_o.pll_rst) && strap_quiet
    |-> !rst_o.boot_start) else $error("boot on quiet strap");
  a_boot_pulse: assert property ($fell(rst_o.pll_rst) && !strap_quiet
    |-> rst_o.boot_start ##1 !rst_o.boot_start) else $error("boot pulse");
  a_wdog_down: assert property (wdog_enable_i && !wdog_reload_i && !wdog_load_wr_i
    && wdog_count_o != 0 |=> wdog_count_o == $past(wdog_count_o) - 1) else $error("no count");
  a_wdog_reset: assert property (wdog_enable_i && wdog_count_o == 0 |-> ##[1:3]
    rst_o.core_rst && rst_o.periph_rst && reset_out_warm_reset_in_oe_o) else $error("no wdog rst");
endmodule
bind bsrc_top bsrc_checker #(.WDOG_W(WDOG_W), .PULSE_CYC(PULSE_CYC)) bsrc_checker_inst (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wide_straps_i(wide_straps_i),
  .boot_select_pins_i(boot_select_pins_i),
  .reset_out_warm_reset_in_n_i(reset_out_warm_reset_in_n_i),
  .reset_out_warm_reset_in_oe_o(reset_out_warm_reset_in_oe_o),
  .wdog_load_wr_i(wdog_load_wr_i),
  .wdog_reload_i(wdog_reload_i),
  .wdog_enable_i(wdog_enable_i),
  .wdog_count_o(wdog_count_o),
  .boot_mode_o(boot_mode_o),
  .boot_reserved_o(boot_reserved_o),
  .rst_o(rst_o)
);
`default_nettype wire

/* File: sim/bsrc_top_tb_top.sv */
// Purpose: bench for boot select and reset control
// Assumes: straps held steady across each power-on reset
// Notes: short reset pulse keeps the run brief
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module bsrc_top_tb_top;
  localparam int PC = 4;
  logic clk_i = 0, rst_i = 1, wide = 1, req = 0, ld = 0, rl = 0, en = 0;
  logic [2:0] code = 3'h0;
  logic [31:0] lv = 32'h0000000a;
  logic [2:0] pins;
  logic pin_n, wide_s, pin_o, oe, rsv;
  logic [31:0] cnt;
  bsrc_pkg::bsrc_boot_t mode;
  bsrc_pkg::bsrc_rst_t r;
  int err_total = 0, total_checks = 0, n;
  initial forever #5 clk_i = ~clk_i;
  bsrc_board bsrc_board_inst (.oe_i(oe), .req_i(req), .wide_i(wide), .code_i(code),
    .wide_o(wide_s), .pins_o(pins), .pin_n_o(pin_n));
  bsrc_top #(.PULSE_CYC(PC)) bsrc_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wide_straps_i(wide_s), .boot_select_pins_i(pins), .reset_out_warm_reset_in_n_i(pin_n),
    .reset_out_warm_reset_in_n_o(pin_o), .reset_out_warm_reset_in_oe_o(oe),
    .wdog_load_wr_i(ld), .wdog_load_val_i(lv), .wdog_reload_i(rl), .wdog_enable_i(en),
    .wdog_count_o(cnt), .boot_mode_o(mode), .boot_reserved_o(rsv), .rst_o(r));
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // bounded wait on one bit of the reset bundle
  task automatic wt(input int b, input logic lvl);
    for (n = 0; n < 80 && r[b] !== lvl; n++) @(negedge clk_i);
    if (r[b] !== lvl) begin
      err_total++;
      end_of_test();
    end
  endtask
  task automatic por(input logic w, input logic [2:0] c);
    bsrc_pkg::bsrc_boot_t e;
    logic b;
    wide = w;
    code = c;
    rst_i = 1;
    repeat (5) @(negedge clk_i);
    rst_i = 0;
    wt(2, 1'b0);
    `CHK(n, PC + 1)
    if (w) e = c[2] ? bsrc_pkg::BSRC_BOOT_RESERVED : bsrc_pkg::bsrc_boot_t'(c);
    else e = c[1:0] == 2'h2 ? bsrc_pkg::BSRC_BOOT_RESERVED : bsrc_pkg::bsrc_boot_t'({1'b0, c[1:0]});
    // rom execution and reserved straps load nothing
    b = w ? !(c[2] || c == 3'h3) : !c[1];
    `CHK(r.boot_start, b)
    @(negedge clk_i);
    `CHK(mode, e)
    `CHK(rsv, e == bsrc_pkg::BSRC_BOOT_RESERVED)
    `CHK({r, oe}, 6'h00)
    `CHK(pin_o, 1'b0)
  endtask
  task automatic test_boot();
    for (int c = 0; c < 8; c++) por(1'b1, c[2:0]);
    for (int c = 0; c < 4; c++) por(1'b0, c[2:0]);
  endtask
  // straps change after boot; mode must not follow
  task automatic test_warm();
    code = 3'h5;
    req = 1;
    wt(4, 1'b1);
    `CHK(r, 5'h18)
    req = 0;
    repeat (PC - 1) @(negedge clk_i);
    `CHK(r.core_rst, 1'b1)
    @(negedge clk_i);
    `CHK(r, 5'h00)
    `CHK(mode, bsrc_pkg::BSRC_BOOT_ASYNC_FLASH)
  endtask
  task automatic test_wdog();
    logic [31:0] a;
    ld = 1;
    @(negedge clk_i);
    ld = 0;
    en = 1;
    repeat (3) @(negedge clk_i);
    a = cnt;
    `CHK(a, lv - 32'h3)
    @(negedge clk_i);
    `CHK(cnt, a - 32'h1)
    rl = 1;
    @(negedge clk_i);
    rl = 0;
    `CHK(cnt, lv)
    wt(4, 1'b1);
    `CHK({r, oe}, 6'h31)
    en = 0;
    wt(4, 1'b0);
  endtask
  initial begin
    test_boot();
    por(1'b1, 3'h2);
    test_warm();
    test_wdog();
    end_of_test();
  end
endmodule
`default_nettype wire
